// >>> common/tm_pkg.sv
// Package for the dual timer/event counter block.
// Holds register indices, control field positions, reset values and state types.
package tm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_C0_DATA = 6'h0D;
    localparam logic [5:0] IDX_C0_CTRL = 6'h0E;
    localparam logic [5:0] IDX_C1_HIGH = 6'h0F;
    localparam logic [5:0] IDX_C1_LOW = 6'h10;
    localparam logic [5:0] IDX_C1_CTRL = 6'h11;
    localparam logic [5:0] IDX_IRQ_CTRL = 6'h0B;

    // Control register field positions
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_CLK_SEL = 5;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_EDGE = 3;
    localparam int CTRL_PSC_HI = 2;

    // Interrupt control register field positions
    localparam int IRQ_EN0_BIT = 2;
    localparam int IRQ_EN1_BIT = 3;
    localparam int IRQ_FLAG0_BIT = 5;
    localparam int IRQ_FLAG1_BIT = 6;

    // Mode codes
    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    // Reset values and limits
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [15:0] TOP_C0 = 16'h00FF;
    localparam logic [15:0] TOP_C1 = 16'hFFFF;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    // One counter channel
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [15:0] preload;
        logic [6:0] psc;
        logic measuring;
        logic [2:0] pinSync;
    } tm_cnt_s;

    // Whole block state
    typedef struct packed {
        tm_cnt_s c0;
        tm_cnt_s c1;
        logic [7:0] lowBuf;
        logic flag0;
        logic flag1;
        logic ie0;
        logic ie1;
        logic [1:0] div4;
        logic [31:0] prdata;
        logic pslverr;
        logic wake;
    } tm_state_s;

endpackage

// >>> logic/tm_dual_timer.sv
// Dual timer/event counter: an 8-bit and a 16-bit count-up counter behind an APB slave.
// Assumes rcTick is a one-cycle pulse per internal RC oscillator period, already in
// the core_clk domain; counter input pins are asynchronous and synchronised here.
//
// Summary of operation
// - Counter 0 is 8-bit, counts pin edges or system/RC clock ticks.
// - Counter 1 is 16-bit, counts pin edges or system/4 or RC ticks.
// - Counter 0 data write sets preload; read returns live count.
// - Counter 1 low-byte write only stores into the low-byte buffer.
// - Counter 1 high-byte write loads preload from written byte and buffer.
// - Counter 1 high-byte read returns high count, copies low count to buffer.
// - Counter 1 low-byte read returns the buffer, not the live count.
// - Control bits 7:6 select event, timer or pulse-width mode; 00 unused.
// - Event/timer count from current value; past all-ones reload from preload.
// - Overflow sets counter's flag: bit 5 for counter 0, bit 6 for 1.
// - Pulse mode starts on chosen edge, stops on return, clears run bit.
// - Finished measurement is held until software sets run again.
// - Pulse mode overflow reloads and raises the flag as well.
// - Counting only while run bit 4 set; event/timer only software clears.
// - Either overflow is presented as a wake-up request.
// - Interrupt enable written 0 disables that counter's interrupt output.
// - Preload write while stopped also loads count; running updates preload only.
// - Counting clock blocked while software reads the count.
// - Counter 0 bits 2:0 divide its clock by two to the field value.
// - Counter 1 bits 2:0 divide its internal clock the same way.
// - Edge bit 3 picks counted edge or pulse start and stop edges.
// - Clock-source bit 5: 0 system clock, 1 RC; counter 1 system/4.
`timescale 1ns/1ps

module tm_dual_timer
    import tm_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rcTick,
    input wire logic counter0InputPin,
    input wire logic counter1InputPin,
    output logic counter0Irq,
    output logic counter1Irq,
    output logic wakeRequest
);

    tm_state_s state;
    tm_state_s next_state;

    // One counter step: synchroniser, prescaler, mode sequencing, overflow
    function automatic tm_cnt_s tm_step(
        input tm_cnt_s c,
        input logic pin,
        input logic srcTick,
        input logic hold,
        input logic [15:0] top,
        output logic ovf
    );
        tm_cnt_s n;
        logic run;
        logic edgeSel;
        logic rise;
        logic fall;
        logic pTick;
        logic inc;
        logic [6:0] mask;
        n = c;
        ovf = 1'b0;
        inc = 1'b0;
        pTick = 1'b0;
        run = c.ctrl[CTRL_RUN];
        edgeSel = c.ctrl[CTRL_EDGE];
        // Two-flop synchroniser, third flop for edge detection
        n.pinSync = {c.pinSync[1:0], pin};
        rise = c.pinSync[1] & ~c.pinSync[2];
        fall = ~c.pinSync[1] & c.pinSync[2];
        // Prescaler: tick out every 2^field source ticks
        mask = 7'((8'h01 << c.ctrl[CTRL_PSC_HI:0]) - 8'h01);
        if (run && srcTick && c.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] != MODE_EVENT) begin
            n.psc = c.psc + 7'h01;
            pTick = ((c.psc & mask) == mask);
        end
        // Mode sequencing
        unique case (c.ctrl[CTRL_MODE_HI:CTRL_MODE_LO])
            MODE_EVENT: begin
                inc = run && (edgeSel ? fall : rise);
            end
            MODE_TIMER: begin
                inc = run && pTick;
            end
            MODE_PULSE: begin
                if (run && !c.measuring) begin
                    // Start on selected transition
                    n.measuring = edgeSel ? rise : fall;
                end else if (run) begin
                    if (edgeSel ? fall : rise) begin
                        // Stop, clear run; result held until rearmed
                        n.measuring = 1'b0;
                        n.ctrl[CTRL_RUN] = 1'b0;
                    end else begin
                        inc = pTick;
                    end
                end
            end
            MODE_UNUSED: begin
                inc = 1'b0;
            end
        endcase
        if (!run) begin
            n.measuring = 1'b0;
        end
        // Count up, reload at all-ones; blocked during a count read
        if (inc && !hold) begin
            if (c.count == top) begin
                n.count = c.preload;
                ovf = 1'b1;
            end else begin
                n.count = c.count + 16'h0001;
            end
        end
        return n;
    endfunction

    logic setup;
    logic access;
    logic wrAccess;
    logic rdAccess;
    logic aligned;
    logic [5:0] idx;
    logic selC0Data;
    logic selC0Ctrl;
    logic selC1High;
    logic selC1Low;
    logic selC1Ctrl;
    logic selIrq;
    logic selAny;
    logic rdBlock0;
    logic rdBlock1;
    logic src0;
    logic src1;
    logic ovf0;
    logic ovf1;
    logic [7:0] rdByte;
    logic [7:0] irqByte;

    // APB phase decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAccess = access & pwrite;
    assign rdAccess = access & ~pwrite;
    assign aligned = (paddr[1:0] == 2'h0);
    assign idx = paddr[7:2];

    // One select per mapped register; unaligned addresses select nothing
    assign selC0Data = aligned & (idx == IDX_C0_DATA);
    assign selC0Ctrl = aligned & (idx == IDX_C0_CTRL);
    assign selC1High = aligned & (idx == IDX_C1_HIGH);
    assign selC1Low = aligned & (idx == IDX_C1_LOW);
    assign selC1Ctrl = aligned & (idx == IDX_C1_CTRL);
    assign selIrq = aligned & (idx == IDX_IRQ_CTRL);
    assign selAny = selC0Data | selC0Ctrl | selC1High | selC1Low | selC1Ctrl | selIrq;

    // Count reads hold the counting clock through setup and access
    assign rdBlock0 = psel & ~pwrite & selC0Data;
    assign rdBlock1 = psel & ~pwrite & selC1High;
    // Internal clock source selection
    assign src0 = state.c0.ctrl[CTRL_CLK_SEL] ? rcTick : 1'b1;
    assign src1 = state.c1.ctrl[CTRL_CLK_SEL] ? rcTick : (state.div4 == DIV4_LAST);

    // Next-state logic: counters, flags, register writes and read capture
    always_comb begin
        next_state = state;
        next_state.div4 = state.div4 + 2'h1;
        next_state.c0 = tm_step(state.c0, counter0InputPin, src0, rdBlock0, TOP_C0, ovf0);
        next_state.c1 = tm_step(state.c1, counter1InputPin, src1, rdBlock1, TOP_C1, ovf1);
        next_state.wake = ovf0 | ovf1;

        // Interrupt control register image
        irqByte = 8'h00;
        irqByte[IRQ_EN0_BIT] = state.ie0;
        irqByte[IRQ_EN1_BIT] = state.ie1;
        irqByte[IRQ_FLAG0_BIT] = state.flag0;
        irqByte[IRQ_FLAG1_BIT] = state.flag1;

        // Read multiplexer; the selects are mutually exclusive
        rdByte = 8'h00;
        if (selC0Data) begin
            rdByte = state.c0.count[7:0];
        end
        if (selC0Ctrl) begin
            rdByte = state.c0.ctrl;
        end
        if (selC1High) begin
            rdByte = state.c1.count[15:8];
        end
        if (selC1Low) begin
            rdByte = state.lowBuf;
        end
        if (selC1Ctrl) begin
            rdByte = state.c1.ctrl;
        end
        if (selIrq) begin
            rdByte = irqByte;
        end

        // Read data and error captured in setup, presented in access
        if (setup) begin
            next_state.pslverr = ~selAny;
            next_state.prdata = {24'h00_0000, rdByte};
        end

        // High-byte read copies the live low byte into the buffer
        if (rdAccess && selC1High) begin
            next_state.lowBuf = state.c1.count[7:0];
        end

        // Counter 0 data: preload always, count too while stopped
        if (wrAccess && selC0Data) begin
            next_state.c0.preload = {8'h00, pwdata[7:0]};
            if (!state.c0.ctrl[CTRL_RUN]) begin
                next_state.c0.count = {8'h00, pwdata[7:0]};
            end
        end

        // Counter 0 control; a software write wins over a pulse-mode stop
        if (wrAccess && selC0Ctrl) begin
            next_state.c0.ctrl = pwdata[7:0];
        end

        // Counter 1 low byte goes to the buffer only
        if (wrAccess && selC1Low) begin
            next_state.lowBuf = pwdata[7:0];
        end

        // Counter 1 high byte loads preload together with the buffer
        if (wrAccess && selC1High) begin
            next_state.c1.preload = {pwdata[7:0], state.lowBuf};
            if (!state.c1.ctrl[CTRL_RUN]) begin
                next_state.c1.count = {pwdata[7:0], state.lowBuf};
            end
        end

        // Counter 1 control
        if (wrAccess && selC1Ctrl) begin
            next_state.c1.ctrl = pwdata[7:0];
        end

        // Interrupt enables; software may only clear flags by writing 0
        if (wrAccess && selIrq) begin
            next_state.ie0 = pwdata[IRQ_EN0_BIT];
            next_state.ie1 = pwdata[IRQ_EN1_BIT];
            next_state.flag0 = state.flag0 & pwdata[IRQ_FLAG0_BIT];
            next_state.flag1 = state.flag1 & pwdata[IRQ_FLAG1_BIT];
        end

        // Overflow sets the flag; set wins over a same-cycle clear
        if (ovf0) begin
            next_state.flag0 = 1'b1;
        end
        if (ovf1) begin
            next_state.flag1 = 1'b1;
        end
    end

    // State register with synchronous reset; counters start off
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= '0;
            state.c0.ctrl <= CTRL_RESET;
            state.c1.ctrl <= CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Bus and interrupt outputs
    assign prdata = state.prdata;
    assign pslverr = state.pslverr & access;
    assign pready = access;
    assign counter0Irq = state.flag0 & state.ie0;
    assign counter1Irq = state.flag1 & state.ie1;
    assign wakeRequest = state.wake;

endmodule

// >>> tb/tm_properties.sv
// Assertions on the timer block's APB and interrupt pins.
// Bound to every tm_dual_timer; one clock domain, synchronous reset.
`timescale 1ns/1ps
module tm_properties (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic counter0Irq,
    input wire logic counter1Irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic mapped;
    // Decoded register addresses
    assign mapped = paddr inside {8'h2C, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
    // Access phases in general and to the interrupt register
    sequence acc;
        psel && penable;
    endsequence
    sequence irqWr;
        psel && penable && pwrite && paddr == 8'h2C;
    endsequence
    sequence irqRd;
        psel && penable && !pwrite && paddr == 8'h2C && !pslverr;
    endsequence
    ready_follows_a: assert property (pready == (psel && penable)) else $error("pready wrong");
    err_unmapped_a: assert property (acc ##0 !mapped |-> pslverr) else $error("no slave error");
    err_mapped_a: assert property (acc ##0 mapped |-> !pslverr) else $error("bad slave error");
    upper_zero_a: assert property (acc ##0 !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    irq0_off_a: assert property (irqWr ##0 !pwdata[2] |=> !counter0Irq)
        else $error("irq0 after disable");
    irq1_off_a: assert property (irqWr ##0 !pwdata[3] |=> !counter1Irq)
        else $error("irq1 after disable");
    flag0_irq_a: assert property (irqRd ##0 (prdata[5] && prdata[2]) |-> counter0Irq)
        else $error("irq0 missing");
    flag1_irq_a: assert property (irqRd ##0 (prdata[6] && prdata[3]) |-> counter1Irq)
        else $error("irq1 missing");
    no_en0_a: assert property (irqRd ##0 !prdata[2] |-> !counter0Irq)
        else $error("irq0 while disabled");
endmodule
bind tm_dual_timer tm_properties u_props (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter0Irq(counter0Irq), .counter1Irq(counter1Irq));

// >>> tb/tb.sv
// Self-checking bench for the dual timer block.
// Drives APB, the RC tick and both input pins directly.
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, rcTick = 0, err;
    logic irq0, irq1, wake;
    int wakes = 0;
    logic [1:0] pins = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr;
    int failCount = 0, nChecks = 0, cyc = 0;
    `define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failCount++; \
        $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
    // Clock
    always #10 core_clk = ~core_clk;
    tm_dual_timer DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rcTick(rcTick), .counter0InputPin(pins[0]),
        .counter1InputPin(pins[1]), .counter0Irq(irq0), .counter1Irq(irq1), .wakeRequest(wake));
    // RC tick every eighth cycle, and the hang limit
    always @(posedge core_clk) begin
        rcTick <= (cyc % 8 == 0);
        cyc <= cyc + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (cyc == 20000) begin
            failCount++;
            wrap_up();
        end
    end
    task wrap_up();
        if (failCount == 0 && nChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d});
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        apb(0, a, 0);
        `CHK(rd, {24'h0, e})
    endtask
    // Counter 1 count, high byte first
    task rd1(output logic [15:0] v);
        apb(0, 8'h3C, 0);
        v[15:8] = rd[7:0];
        apb(0, 8'h40, 0);
        v[7:0] = rd[7:0];
    endtask
    task pulses(input int p, n, w);
        repeat (n) begin
            @(posedge core_clk);
            pins[p] <= 1;
            repeat (w) @(posedge core_clk);
            pins[p] <= 0;
            repeat (w) @(posedge core_clk);
        end
    endtask
    task t_reset;
        rdc(8'h38, 8'h08);
        rdc(8'h44, 8'h08);
        apb(0, 8'h00, 0);
        `CHK(err, 1'b1)
        apb(1, 8'h35, 1);
        `CHK(err, 1'b1)
    endtask
    task t_buf;
        wr(8'h40, 8'h34);
        wr(8'h3C, 8'h12);
        wr(8'h40, 8'h55);
        rdc(8'h3C, 8'h12);
        rdc(8'h40, 8'h34);
    endtask
    // Run 200 cycles from zero, then compare the count with a window
    task measure(input logic [7:0] ca, input logic [7:0] c, input int lo, hi);
        logic [15:0] v;
        wr(ca, 8'h00);
        if (ca == 8'h38) wr(8'h34, 0);
        else begin
            wr(8'h40, 0);
            wr(8'h3C, 0);
        end
        wr(ca, c);
        repeat (197) @(posedge core_clk);
        wr(ca, 8'h00);
        if (ca == 8'h38) begin
            apb(0, 8'h34, 0);
            v = rd[15:0];
        end else rd1(v);
        `CHK(v >= lo && v <= hi, 1'b1)
    endtask
    task t_ovf;
        wr(8'h38, 8'h00);
        wr(8'h34, 8'hFE);
        wr(8'h2C, 8'h04);
        wr(8'h38, 8'h90);
        repeat (5) @(posedge core_clk);
        `CHK(irq0, 1'b1)
        `CHK(wakes > 0, 1'b1)
        apb(0, 8'h34, 0);
        `CHK(rd[7:0] >= 8'hFE, 1'b1)
        wr(8'h38, 8'h00);
        apb(0, 8'h2C, 0);
        `CHK(rd[5], 1'b1)
        wr(8'h2C, 8'h20);
        @(posedge core_clk);
        `CHK(irq0, 1'b0)
    endtask
    // Counter 1 overflow flag and its interrupt enable
    task t_ovf1;
        wr(8'h44, 8'h00);
        wr(8'h40, 8'hFF);
        wr(8'h3C, 8'hFF);
        wr(8'h2C, 8'h08);
        wr(8'h44, 8'h90);
        repeat (10) @(posedge core_clk);
        `CHK(irq1, 1'b1)
        apb(0, 8'h2C, 0);
        `CHK(rd[6], 1'b1)
        wr(8'h2C, 8'h40);
        @(posedge core_clk);
        `CHK(irq1, 1'b0)
        wr(8'h44, 8'h00);
    endtask
    task t_event;
        wr(8'h38, 8'h00);
        wr(8'h34, 8'h00);
        wr(8'h38, 8'h50);
        pulses(0, 3, 4);
        rdc(8'h34, 8'h03);
        wr(8'h38, 8'h58);
        pulses(0, 2, 4);
        rdc(8'h34, 8'h05);
    endtask
    task t_pulse;
        logic [15:0] a, b;
        wr(8'h44, 8'h00);
        wr(8'h40, 0);
        wr(8'h3C, 0);
        wr(8'h44, 8'hD8);
        pulses(1, 1, 40);
        rdc(8'h44, 8'hC8);
        rd1(a);
        `CHK(a >= 9 && a <= 11, 1'b1)
        pulses(1, 1, 40);
        rd1(b);
        `CHK(b, a)
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1;
        t_reset;
        t_buf;
        measure(8'h38, 8'h93, 24, 26);
        measure(8'h38, 8'hB0, 24, 26);
        measure(8'h44, 8'h90, 49, 51);
        measure(8'h44, 8'h91, 24, 26);
        measure(8'h44, 8'hB0, 24, 26);
        t_ovf;
        t_ovf1;
        t_event;
        t_pulse;
        wrap_up();
    end
endmodule
